// [core/reference_pulse_decoder.sv]
// reference pulse decoder with axi4-lite register slave
// assumes fwd_pulse_in and rev_pulse_in are asynchronous pins; bus runs on aclk
`timescale 1ns/1ns
module reference_pulse_decoder #(
    parameter int pos_w = 32 // width of the position accumulator
) (
    input wire logic aclk,              // 100 MHz clock
    input wire logic aresetn,           // synchronous reset, active low
    input wire logic fwd_pulse_in,      // pulse / first phase / forward line
    input wire logic rev_pulse_in,      // direction / second phase / reverse line
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,     // write address valid
    output logic s_axi_awready,         // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid,      // write data valid
    output logic s_axi_wready,          // write data ready
    output logic [1:0] s_axi_bresp,     // write response
    output logic s_axi_bvalid,          // write response valid
    input wire logic s_axi_bready,      // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,     // read address valid
    output logic s_axi_arready,         // read address ready
    output logic [31:0] s_axi_rdata,    // read data
    output logic [1:0] s_axi_rresp,     // read response
    output logic s_axi_rvalid,          // read data valid
    input wire logic s_axi_rready       // read data ready
);
    if (pos_w < 2 || pos_w > 32) begin : g_chk
        $error("pos_w must lie in 2..32");
    end

    // filter counters must hold the longest stable time
    if (ref_pulse_pkg::filt_open_cyc >= (1 << ref_pulse_pkg::filt_w)) begin : g_chk_filt
        $error("filter stable time does not fit its counter");
    end

    // two-stage synchronisers, then per-line glitch filters
    localparam int filt_cnt_w = ref_pulse_pkg::filt_w;
    logic [1:0] sync1, sync2, filt, next_filt;
    logic [filt_cnt_w-1:0] fcnt [2];
    logic [filt_cnt_w-1:0] next_fcnt [2];
    logic [1:0] filt_sel;
    logic [filt_cnt_w-1:0] filt_lim;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= {rev_pulse_in, fwd_pulse_in};
            sync2 <= sync1;
        end
    end

    // stable time chosen by the filter setting
    always_comb begin
        case (filt_sel)
            ref_pulse_pkg::filt_open: filt_lim = filt_cnt_w'(ref_pulse_pkg::filt_open_cyc);
            ref_pulse_pkg::filt_line2: filt_lim = filt_cnt_w'(ref_pulse_pkg::filt_line2_cyc);
            default: filt_lim = filt_cnt_w'(ref_pulse_pkg::filt_line_cyc);
        endcase
    end

    // a line level is accepted only after it has stood filt_lim cycles
    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_comb begin
            next_filt[i] = filt[i];
            next_fcnt[i] = '0;
            if (sync2[i] != filt[i]) begin
                if (fcnt[i] >= filt_lim - 1'b1) begin
                    next_filt[i] = sync2[i];
                end else begin
                    next_fcnt[i] = fcnt[i] + 1'b1;
                end
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                fcnt[i] <= '0;
            end else begin
                fcnt[i] <= next_fcnt[i];
            end
        end
    end

    // filtered levels and their previous values; reset to idle low
    logic [1:0] prev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt <= 2'h0;
            prev <= 2'h0;
        end else begin
            filt <= next_filt;
            prev <= filt;
        end
    end

    // registers
    logic [3:0] ctrl_req, ctrl_act, form;
    logic [pos_w-1:0] position;
    logic enabled;

    // decode one step from the filtered lines according to the pulse form
    ref_pulse_pkg::step_t step;
    logic a, b, pa, pb, a_rise, b_rise, a_edge, b_edge;
    always_comb begin
        a = filt[0];
        b = filt[1];
        pa = prev[0];
        pb = prev[1];
        a_rise = a & ~pa;
        b_rise = b & ~pb;
        a_edge = a ^ pa;
        b_edge = b ^ pb;
        // forward when phase b leads phase a: a rises while b high etc.
        // quadrature: an edge on one line is read against the other line's level
        step = '0;
        case (form)
            ref_pulse_pkg::form_sign_pos: begin
                step.fwd = a_rise & b;
                step.rev = a_rise & ~b;
            end
            ref_pulse_pkg::form_sign_neg: begin
                step.fwd = a_rise & ~b;
                step.rev = a_rise & b;
            end
            ref_pulse_pkg::form_cwccw_pos: begin
                step.fwd = a_rise & ~b_rise;
                step.rev = b_rise & ~a_rise;
            end
            ref_pulse_pkg::form_cwccw_neg: begin
                step.fwd = (~a & pa) & ~(~b & pb);
                step.rev = (~b & pb) & ~(~a & pa);
            end
            ref_pulse_pkg::form_quad_x1: begin
                step.fwd = a_rise & ~b_edge & b;
                step.rev = a_rise & ~b_edge & ~b;
            end
            ref_pulse_pkg::form_quad_x2: begin
                step.fwd = a_edge & ~b_edge & (a == b);
                step.rev = a_edge & ~b_edge & (a != b);
            end
            ref_pulse_pkg::form_quad_x4: begin
                step.fwd = (a_edge ^ b_edge) & (a_edge ? (a == b) : (a != b));
                step.rev = (a_edge ^ b_edge) & (a_edge ? (a != b) : (a == b));
            end
            default: step = '0;
        endcase
    end

    // position accumulator; counts only under position control
    logic [pos_w-1:0] next_position;
    always_comb begin
        next_position = position;
        if (enabled && step.fwd) begin
            next_position = position + 1'b1;
        end else if (enabled && step.rev) begin
            next_position = position - 1'b1;
        end
    end

    // axi4-lite slave state
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] awaddr_q, next_awaddr_q;
    logic [31:0] wdata_q, next_wdata_q;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [3:0] next_ctrl_req, next_ctrl_act, next_form;
    logic [1:0] next_filt_sel;
    logic next_enabled, do_write, restart;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        // each channel is taken only at an edge where its ready stands
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_awaddr_q = s_axi_awaddr;
        end
        // unstrobed bytes are stored as zero
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wdata_q = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        do_write = aw_held && w_held && !bvalid;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl_req = ctrl_req;
        next_form = form;
        next_filt_sel = filt_sel;
        restart = 1'b0;
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ref_pulse_pkg::resp_okay;
            case (awaddr_q)
                ref_pulse_pkg::off_control: next_ctrl_req = wdata_q[3:0];
                ref_pulse_pkg::off_config: begin
                    next_form = wdata_q[ref_pulse_pkg::form_lsb +: 4];
                    next_filt_sel = wdata_q[ref_pulse_pkg::filt_lsb +: 2];
                end
                ref_pulse_pkg::off_restart: restart = wdata_q[0];
                ref_pulse_pkg::off_position, ref_pulse_pkg::off_status: ;
                default: next_bresp = ref_pulse_pkg::resp_slverr;
            endcase
        end
        // control method takes effect only at restart
        next_ctrl_act = restart ? ctrl_req : ctrl_act;
        next_enabled = (next_ctrl_act == ref_pulse_pkg::ctrl_position);
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // a read is taken only while arready stands
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = ref_pulse_pkg::resp_okay;
            case (s_axi_araddr)
                ref_pulse_pkg::off_control: next_rdata = {28'h0000000, ctrl_req};
                ref_pulse_pkg::off_config: next_rdata = {18'h00000, filt_sel, 8'h00, form};
                ref_pulse_pkg::off_position: next_rdata = 32'(signed'(position));
                ref_pulse_pkg::off_status: next_rdata = {23'h000000, enabled, 4'h0, ctrl_act};
                ref_pulse_pkg::off_restart: next_rdata = 32'h00000000;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = ref_pulse_pkg::resp_slverr;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rresp <= 2'h0;
            rdata <= 32'h00000000;
            ctrl_req <= ref_pulse_pkg::ctrl_reset;
            ctrl_act <= ref_pulse_pkg::ctrl_reset;
            form <= ref_pulse_pkg::form_sign_pos;
            filt_sel <= ref_pulse_pkg::filt_line;
            enabled <= 1'b0;
            position <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            ctrl_req <= next_ctrl_req;
            ctrl_act <= next_ctrl_act;
            form <= next_form;
            filt_sel <= next_filt_sel;
            enabled <= next_enabled;
            position <= restart ? '0 : next_position;
        end
    end

    // ready flags come from flip-flops: each open while its own channel holds nothing and its answer is not pending
    logic awready_q, wready_q, arready_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            awready_q <= !next_aw_held && !next_bvalid;
            wready_q <= !next_w_held && !next_bvalid;
            arready_q <= !next_rvalid;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
endmodule : reference_pulse_decoder

// [shared/ref_pulse_pkg.sv]
// constants, register map and carrier types for the reference pulse decoder
// assumes a 100 MHz aclk and an axi4-lite register bus with 32-bit data
// What this block does
// - pulses count only when control method select holds the position code; latched at restart
// - form 0: each pulse counts forward while direction high, reverse while low
// - form 5: count forward while direction low, reverse while high
// - form 1: first line pulses forward, second line reverse; idle low
// - form 6: as form 1 with both lines inverted; idle high
// - forms 2, 3, 4: quadrature with one, two, four counts per cycle
// - quadrature: forward when second phase leads first, reverse when it lags
// - quadrature input up to 1 Mpps before multiplication must be accepted
// - pulse forms accept up to 4 Mpps; host stays within that
// - filter 0 line driver up to 1 Mpps; filter 1 open collector 200 kpps
// - filter 2 second line driver filter for 1 to 4 Mpps
package ref_pulse_pkg;
    // register byte offsets
    localparam logic [7:0] off_control = 8'h00; // control method select, latched at restart
    localparam logic [7:0] off_config = 8'h04;  // pulse form [3:0], filter [13:12]
    localparam logic [7:0] off_position = 8'h08; // signed accumulated position
    localparam logic [7:0] off_status = 8'h0c;  // active control method, enabled flag
    localparam logic [7:0] off_restart = 8'h10; // write 1 in bit 0 to restart
    // field layout and values
    localparam int form_lsb = 0;
    localparam int filt_lsb = 12;
    localparam logic [3:0] ctrl_position = 4'h1; // position control code
    localparam logic [3:0] ctrl_reset = 4'h0;
    localparam logic [3:0] form_sign_pos = 4'h0;
    localparam logic [3:0] form_cwccw_pos = 4'h1;
    localparam logic [3:0] form_quad_x1 = 4'h2;
    localparam logic [3:0] form_quad_x2 = 4'h3;
    localparam logic [3:0] form_quad_x4 = 4'h4;
    localparam logic [3:0] form_sign_neg = 4'h5;
    localparam logic [3:0] form_cwccw_neg = 4'h6;
    localparam logic [1:0] filt_line = 2'h0;
    localparam logic [1:0] filt_open = 2'h1;
    localparam logic [1:0] filt_line2 = 2'h2;
    // filter stable times in ns, half of the shortest level at the filter's top rate
    localparam int clk_ns = 10;
    localparam int filt_line_ns = 250;  // 1 Mpps: 500 ns half period
    localparam int filt_open_ns = 1250; // 200 kpps: 2500 ns half period
    localparam int filt_line2_ns = 60;  // 4 Mpps: 125 ns half period
    localparam int filt_line_cyc = filt_line_ns / clk_ns;
    localparam int filt_open_cyc = filt_open_ns / clk_ns;
    localparam int filt_line2_cyc = filt_line2_ns / clk_ns;
    localparam int filt_w = 8;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // one count step out of the decoder
    typedef struct packed {
        logic fwd;
        logic rev;
    } step_t;

    // axi4-lite write request payload
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;
endpackage : ref_pulse_pkg

// [tb/pulse_host.sv]
// model of the host motion controller driving the two reference pulse lines
// assumes the decoder samples both lines asynchronously; times are in ns
`timescale 1ns/1ns
module pulse_host #(
    parameter int lead_ns = 2000 // quiet lead before a train, shortened
) (
    output logic fwd_pulse_in, // pulse, forward or phase a line
    output logic rev_pulse_in // direction, reverse or phase b line
);
    // line drivers rest low
    initial begin
        fwd_pulse_in = 1'b0;
        rev_pulse_in = 1'b0;
    end
    // set idle levels, then stay quiet before the first pulse
    task automatic idle(input logic a, input logic b);
        fwd_pulse_in = a;
        rev_pulse_in = b;
        #(lead_ns);
    endtask : idle
    // n pulses on one line; callers keep hi + lo at 250 ns or more
    task automatic train(input logic on_b, input logic act, input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            fwd_pulse_in = on_b ? fwd_pulse_in : act;
            rev_pulse_in = on_b ? act : rev_pulse_in;
            #(hi);
            fwd_pulse_in = on_b ? fwd_pulse_in : ~act;
            rev_pulse_in = on_b ? ~act : rev_pulse_in;
            #(lo);
        end
    endtask : train
    // quadrature cycles from 00, a quarter period apart; phase b leads for forward
    task automatic quad(input logic fwd, input int n, input int q);
        for (int i = 0; i < 4 * n; i++) begin
            #(q);
            if ((i % 2 == 0) == fwd)
                rev_pulse_in = ~rev_pulse_in;
            else
                fwd_pulse_in = ~fwd_pulse_in;
        end
    endtask : quad
endmodule : pulse_host

// [tb/ref_pulse_props.sv]
// checks on the decoder's axi4-lite slave answers
// assumes a bind to the decoder top; sees its ports only
`timescale 1ns/1ns
module ref_pulse_props (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic [7:0] s_axi_awaddr, // aw address
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // ar address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready // r ready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // requests taken, and whether their offset is a mapped register
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire aw_map = s_axi_awaddr <= 8'h10 && s_axi_awaddr[1:0] == 2'h0;
    wire ar_map = s_axi_araddr <= 8'h10 && s_axi_araddr[1:0] == 2'h0;
    wr_ok_a: assert property (wr_take && aw_map
        |-> ##2 s_axi_bvalid && s_axi_bresp == ref_pulse_pkg::resp_okay) else $error("write not answered okay");
    wr_err_a: assert property (wr_take && s_axi_awaddr > 8'h10
        |-> ##2 s_axi_bvalid && s_axi_bresp == ref_pulse_pkg::resp_slverr) else $error("bad write not refused");
    rd_ok_a: assert property (ar_take && ar_map
        |=> s_axi_rvalid && s_axi_rresp == ref_pulse_pkg::resp_okay) else $error("read not answered okay");
    rd_err_a: assert property (ar_take && s_axi_araddr > 8'h10
        |=> s_axi_rvalid && s_axi_rresp == ref_pulse_pkg::resp_slverr && s_axi_rdata == 32'h0)
        else $error("bad read not refused");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
    b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while answering");
    r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready while answering");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");
    aw_drop_a: assert property (wr_take |=> !s_axi_awready [*2]) else $error("write ready not dropped");
endmodule : ref_pulse_props

// [tb/testbench.sv]
// self-checking bench for the reference pulse decoder
// assumes the host model drives the pins and the bench is the axi4-lite master
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fwd_pulse_in, rev_pulse_in;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0, n_checks = 0, cycles = 0;

    reference_pulse_decoder u_reference_pulse_decoder (.*);
    pulse_host u_pulse_host (.*);

    // 100 MHz clock
    always #5 aclk = ~aclk;
    // cycle ceiling well above the run's length of some 15000 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            $display("unexpected at %0t: run timed out", $time);
            finish_test();
        end
    end
    // count one comparison, report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // one write; each channel released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            // what the slave samples at the next edge, settled mid-cycle
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    // one read; rready is raised only once the answer stands, so it is held a cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t, r_up;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid && s_axi_rready;
            r_up = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) begin
                s_axi_rready <= 1'b0;
                break;
            end
            if (r_up) s_axi_rready <= 1'b1;
        end
    endtask : rd
    // read and compare data and response
    task automatic rdck(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input string what);
        logic [31:0] v;
        logic [1:0] q;
        rd(a, v, q);
        check(v, d, what);
        check(32'(q), 32'(r), what);
    endtask : rdck
    // write and compare the response
    task automatic wck(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input string what);
        logic [1:0] q;
        wr(a, d, q);
        check(32'(q), 32'(r), what);
    endtask : wck
    // set form and filter, send a train and compare the change of position
    task automatic step(input logic [3:0] form, input logic [1:0] filt, input logic a, input logic b,
                        input logic on_b, input logic act, input int n, input int hi, input int lo, input int dlt);
        logic [31:0] p0, p1;
        logic [1:0] r;
        wr(ref_pulse_pkg::off_config, (32'(form) << ref_pulse_pkg::form_lsb) | (32'(filt) << ref_pulse_pkg::filt_lsb), r);
        u_pulse_host.idle(a, b);
        rd(ref_pulse_pkg::off_position, p0, r);
        if (form >= ref_pulse_pkg::form_quad_x1 && form <= ref_pulse_pkg::form_quad_x4)
            u_pulse_host.quad(act, n, hi);
        else
            u_pulse_host.train(on_b, act, n, hi, lo);
        repeat (300) @(posedge aclk);
        rd(ref_pulse_pkg::off_position, p1, r);
        check(p1, p0 + 32'(dlt), "position change");
    endtask : step
    // reset values, read-only and unmapped places
    task automatic t_reset();
        rdck(ref_pulse_pkg::off_control, 32'h0, ref_pulse_pkg::resp_okay, "control at reset");
        rdck(ref_pulse_pkg::off_status, 32'h0, ref_pulse_pkg::resp_okay, "status at reset");
        wck(ref_pulse_pkg::off_position, 32'h5, ref_pulse_pkg::resp_okay, "read-only write");
        rdck(ref_pulse_pkg::off_position, 32'h0, ref_pulse_pkg::resp_okay, "position at reset");
        rdck(8'h14, 32'h0, ref_pulse_pkg::resp_slverr, "unmapped read");
        wck(8'h14, 32'h1, ref_pulse_pkg::resp_slverr, "unmapped write");
        $display("reset test done");
    endtask : t_reset
    // control method takes effect only at restart
    task automatic t_enable();
        wck(ref_pulse_pkg::off_control, 32'(ref_pulse_pkg::ctrl_position), ref_pulse_pkg::resp_okay, "control");
        rdck(ref_pulse_pkg::off_status, 32'h0, ref_pulse_pkg::resp_okay, "status before restart");
        wck(ref_pulse_pkg::off_restart, 32'h1, ref_pulse_pkg::resp_okay, "restart");
        rdck(ref_pulse_pkg::off_status, 32'h100 | 32'(ref_pulse_pkg::ctrl_position), 2'h0, "status active");
        $display("enable test done");
    endtask : t_enable
    // sign and separate-train forms just under 4 Mpps (260 ns period) through the fast filter
    task automatic t_forms();
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line2, 0, 1, 0, 1, 5, 130, 130, 5);
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line2, 0, 0, 0, 1, 5, 130, 130, -5);
        step(ref_pulse_pkg::form_sign_neg, ref_pulse_pkg::filt_line2, 0, 0, 0, 1, 4, 130, 130, 4);
        step(ref_pulse_pkg::form_sign_neg, ref_pulse_pkg::filt_line2, 0, 1, 0, 1, 4, 130, 130, -4);
        step(ref_pulse_pkg::form_cwccw_pos, ref_pulse_pkg::filt_line2, 0, 0, 0, 1, 3, 130, 130, 3);
        step(ref_pulse_pkg::form_cwccw_pos, ref_pulse_pkg::filt_line2, 0, 0, 1, 1, 3, 130, 130, -3);
        step(ref_pulse_pkg::form_cwccw_neg, ref_pulse_pkg::filt_line2, 1, 1, 0, 0, 3, 130, 130, 3);
        step(ref_pulse_pkg::form_cwccw_neg, ref_pulse_pkg::filt_line2, 1, 1, 1, 0, 3, 130, 130, -3);
        $display("forms test done");
    endtask : t_forms
    // quadrature x1, x2, x4 at 1 Mpps both ways
    task automatic t_quad();
        for (int m = 0; m < 3; m++) begin
            step(ref_pulse_pkg::form_quad_x1 + 4'(m), ref_pulse_pkg::filt_line, 0, 0, 0, 1, 3, 250, 0, 3 << m);
            step(ref_pulse_pkg::form_quad_x1 + 4'(m), ref_pulse_pkg::filt_line, 0, 0, 0, 0, 2, 250, 0, -(2 << m));
        end
        $display("quadrature test done");
    endtask : t_quad
    // filters 0 and 1 pass their top rate; each filter drops a pulse too short for it
    task automatic t_filters();
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_open, 0, 1, 0, 1, 2, 2500, 2500, 2);
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_open, 0, 1, 0, 1, 1, 600, 3000, 0);
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line, 0, 1, 0, 1, 3, 500, 500, 3);
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line, 0, 1, 0, 1, 1, 150, 600, 0);
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line2, 0, 1, 0, 1, 1, 30, 300, 0);
        $display("filter test done");
    endtask : t_filters
    // restart to another control method stops counting
    task automatic t_restart();
        wck(ref_pulse_pkg::off_control, 32'(ref_pulse_pkg::ctrl_reset), ref_pulse_pkg::resp_okay, "control");
        wck(ref_pulse_pkg::off_restart, 32'h1, ref_pulse_pkg::resp_okay, "restart");
        rdck(ref_pulse_pkg::off_status, 32'h0, ref_pulse_pkg::resp_okay, "status inactive");
        step(ref_pulse_pkg::form_sign_pos, ref_pulse_pkg::filt_line2, 0, 1, 0, 1, 3, 130, 130, 0);
        $display("restart test done");
    endtask : t_restart
    // print the counts and the verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_enable();
        t_forms();
        t_quad();
        t_filters();
        t_restart();
        finish_test();
    end
endmodule : testbench

bind reference_pulse_decoder ref_pulse_props u_ref_pulse_props (.*);
